/* backlight_dimming_ctrl_regs.vh */
// register map, field positions, reset values and timing counts
`ifndef BACKLIGHT_DIMMING_CTRL_REGS_VH
`define BACKLIGHT_DIMMING_CTRL_REGS_VH
`define SLAVE_ADDR 7'h2c
`define OFS_BRIGHTNESS 8'h00
`define OFS_DEVICE_CONTROL 8'h01
`define OFS_FAULT_STATE 8'h02
`define RST_BRIGHTNESS 8'hff
`define RST_DEVICE_CONTROL 8'h00
`define RST_FAULT_STATE 8'h00
`define CTL_ON_BIT 0
`define CTL_SRC_BIT 1
`define CTL_MODE_BIT 2
`define CTL_RW_MASK 8'h07
`define FS_ANY_BIT 0
`define FS_THERMAL_BIT 1
`define FS_OVERCURRENT_BIT 2
`define FS_BL_STATE_BIT 3
`define FS_SINGLE_BIT 4
`define FS_MULTI_BIT 5
`define CLK_HZ 50000000
`define TURN_ON_MS 10
`define TURN_ON_CYCLES ((`CLK_HZ / 1000) * `TURN_ON_MS)
`define MIN_DUTY_FLOOR 8'h07
`endif

/* dimming_pwm_gen.v */
// free-running 8-bit dimming pwm generator
`default_nettype none
module dimming_pwm_gen #(
    parameter integer PRESCALE = 98
)
(
    input wire clk,
    input wire rst,
    input wire ce,
    input wire [7:0] duty,
    output reg pwm_out,
    output reg period_start
);
    reg [15:0] pre_r;
    reg [7:0] phase_r;
    reg [7:0] duty_r;
    // duty is latched per period so the edge never glitches mid-cycle
    always @(posedge clk)
    begin
        if (rst)
        begin
            pre_r <= 16'h0000;
            phase_r <= 8'h00;
            duty_r <= 8'h00;
            pwm_out <= 1'b0;
            period_start <= 1'b0;
        end
        else if (ce)
        begin
            period_start <= 1'b0;
            if (pre_r == PRESCALE[15:0] - 16'h0001)
            begin
                pre_r <= 16'h0000;
                phase_r <= phase_r + 8'h01;
                if (phase_r == 8'hff)
                begin
                    duty_r <= duty;
                    period_start <= 1'b1;
                end
                pwm_out <= (duty_r == 8'hff) || (phase_r < duty_r);
            end
            else
            begin
                pre_r <= pre_r + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

/* backlight_dimming_ctrl_regs.v */
// smbus register bank and dimming duty mux of the backlight controller
`include "backlight_dimming_ctrl_regs.vh"
`default_nettype none
module backlight_dimming_ctrl_regs #(
    parameter integer TURN_ON_CYCLES = `TURN_ON_CYCLES,
    parameter integer PRESCALE = 98
)
(
    input wire clk,
    input wire rst,
    input wire ce,
    input wire smb_clk_in,
    input wire smb_data_in,
    output reg smb_data_oe,
    output reg smb_data_out,
    input wire ext_duty_input,
    input wire thermal_fault_in,
    input wire overcurrent_in,
    input wire [7:0] channel_fault_in,
    input wire undervoltage_in,
    output reg led_enable,
    output reg dimming_pwm,
    output reg backlight_on_state,
    output reg [7:0] applied_duty
);
    localparam [6:0] ST_IDLE = 7'b0000001;
    localparam [6:0] ST_ADDR = 7'b0000010;
    localparam [6:0] ST_ACK = 7'b0000100;
    localparam [6:0] ST_WBYTE = 7'b0001000;
    localparam [6:0] ST_RBYTE = 7'b0010000;
    localparam [6:0] ST_RACK = 7'b0100000;
    localparam [6:0] ST_SKIP = 7'b1000000;
    // bit count of a set vector, used for channel fault summary
    function [3:0] pop8;
        input [7:0] v;
        integer k;
        begin
            pop8 = 4'h0;
            for (k = 0; k < 8; k = k + 1)
                pop8 = pop8 + {3'b000, v[k]};
        end
    endfunction
    // synchronisers for every pin-side input
    reg [1:0] scl_s, sda_s, ext_duty_input_s, th_s, oc_s, uv_s;
    reg [7:0] ch_s1, ch_s2;
    always @(posedge clk)
    begin
        if (rst)
        begin
            scl_s <= 2'b11;
            sda_s <= 2'b11;
            ext_duty_input_s <= 2'b00;
            th_s <= 2'b00;
            oc_s <= 2'b00;
            uv_s <= 2'b00;
            ch_s1 <= 8'h00;
            ch_s2 <= 8'h00;
        end
        else if (ce)
        begin
            scl_s <= {scl_s[0], smb_clk_in};
            sda_s <= {sda_s[0], smb_data_in};
            ext_duty_input_s <= {ext_duty_input_s[0], ext_duty_input};
            th_s <= {th_s[0], thermal_fault_in};
            oc_s <= {oc_s[0], overcurrent_in};
            uv_s <= {uv_s[0], undervoltage_in};
            ch_s1 <= channel_fault_in;
            ch_s2 <= ch_s1;
        end
    end
    wire scl = scl_s[1];
    wire sda = sda_s[1];
    reg scl_d, sda_d;
    always @(posedge clk)
    begin
        if (rst)
        begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end
        else if (ce)
        begin
            scl_d <= scl;
            sda_d <= sda;
        end
    end
    wire scl_rise = scl & ~scl_d;
    wire scl_fall = ~scl & scl_d;
    wire start_c = scl & scl_d & sda_d & ~sda;
    wire stop_c = scl & scl_d & ~sda_d & sda;
    // registers
    reg [7:0] brightness_value_r;
    reg [7:0] device_control_r;
    reg [7:0] fault_and_state_r;
    reg [7:0] pin_duty_r;
    wire on_bit = device_control_r[`CTL_ON_BIT];
    wire src_bit = device_control_r[`CTL_SRC_BIT];
    wire duty_interpretation_bit = device_control_r[`CTL_MODE_BIT];
    wire [7:0] ctl_mask = `CTL_RW_MASK;
    // smbus slave: write byte (addr,cmd,data) and read byte (addr,cmd,rs,addr,data)
    reg [6:0] st_r;
    reg [7:0] sh_r;
    reg [3:0] cnt_r;
    reg [1:0] phase_r;
    reg rd_r, ack_r;
    reg [7:0] cmd_r;
    function [7:0] read_mux;
        input [7:0] a, b, c, d;
        begin
            case (a)
                `OFS_BRIGHTNESS: read_mux = b;
                `OFS_DEVICE_CONTROL: read_mux = c & ctl_mask;
                `OFS_FAULT_STATE: read_mux = d;
                default: read_mux = 8'h00;
            endcase
        end
    endfunction
    wire [7:0] rd_val = read_mux(cmd_r, applied_duty, device_control_r, fault_and_state_r);
    always @(posedge clk)
    begin
        if (rst)
        begin
            st_r <= ST_IDLE;
            sh_r <= 8'h00;
            cnt_r <= 4'h0;
            phase_r <= 2'b00;
            rd_r <= 1'b0;
            ack_r <= 1'b0;
            cmd_r <= 8'h00;
            smb_data_oe <= 1'b0;
            smb_data_out <= 1'b0;
            brightness_value_r <= `RST_BRIGHTNESS;
            device_control_r <= `RST_DEVICE_CONTROL;
        end
        else if (ce)
        begin
            if (start_c)
            begin
                st_r <= ST_ADDR;
                cnt_r <= 4'h0;
                smb_data_oe <= 1'b0;
            end
            else if (stop_c)
            begin
                st_r <= ST_IDLE;
                phase_r <= 2'b00;
                smb_data_oe <= 1'b0;
            end
            else
            begin
                case (st_r)
                    ST_IDLE: ;
                    ST_ADDR, ST_WBYTE:
                        if (scl_rise)
                        begin
                            sh_r <= {sh_r[6:0], sda};
                            cnt_r <= cnt_r + 4'h1;
                        end
                        else if (scl_fall && cnt_r == 4'h8)
                        begin
                            cnt_r <= 4'h0;
                            if (st_r == ST_ADDR)
                            begin
                                ack_r <= (sh_r[7:1] == `SLAVE_ADDR);
                                rd_r <= sh_r[0];
                                smb_data_oe <= (sh_r[7:1] == `SLAVE_ADDR);
                                if (sh_r[7:1] != `SLAVE_ADDR)
                                    phase_r <= 2'b00;
                                st_r <= (sh_r[7:1] == `SLAVE_ADDR) ? ST_ACK : ST_SKIP;
                            end
                            else
                            begin
                                smb_data_oe <= 1'b1;
                                ack_r <= 1'b1;
                                st_r <= ST_ACK;
                                if (phase_r == 2'b00)
                                begin
                                    cmd_r <= sh_r;
                                    phase_r <= 2'b01;
                                end
                                else if (cmd_r == `OFS_BRIGHTNESS)
                                begin
                                    if (!src_bit)
                                        brightness_value_r <= sh_r;
                                end
                                else if (cmd_r == `OFS_DEVICE_CONTROL)
                                begin
                                    device_control_r <= sh_r & ctl_mask;
                                end
                            end
                        end
                    ST_ACK:
                        if (scl_fall)
                        begin
                            if (rd_r && ack_r)
                            begin
                                sh_r <= rd_val;
                                smb_data_oe <= ~rd_val[7];
                                cnt_r <= 4'h1;
                                st_r <= ST_RBYTE;
                            end
                            else
                            begin
                                smb_data_oe <= 1'b0;
                                st_r <= ST_WBYTE;
                            end
                        end
                    ST_RBYTE:
                        if (scl_fall)
                        begin
                            if (cnt_r == 4'h8)
                            begin
                                smb_data_oe <= 1'b0;
                                st_r <= ST_RACK;
                            end
                            else
                            begin
                                smb_data_oe <= ~sh_r[6];
                                sh_r <= {sh_r[6:0], 1'b0};
                                cnt_r <= cnt_r + 4'h1;
                            end
                        end
                    ST_RACK:
                        if (scl_fall)
                            st_r <= ST_SKIP;
                    ST_SKIP: ;
                    default: st_r <= ST_IDLE;
                endcase
            end
        end
    end
    // pin duty measurement over one 256-tick window
    reg [15:0] mpre_r;
    reg [7:0] mtick_r, mhigh_r;
    always @(posedge clk)
    begin
        if (rst)
        begin
            mpre_r <= 16'h0000;
            mtick_r <= 8'h00;
            mhigh_r <= 8'h00;
            pin_duty_r <= 8'hff;
        end
        else if (ce)
        begin
            if (mpre_r == PRESCALE[15:0] - 16'h0001)
            begin
                mpre_r <= 16'h0000;
                mtick_r <= mtick_r + 8'h01;
                if (mtick_r == 8'hff)
                begin
                    // all-high window saturates at full scale
                    pin_duty_r <= ext_duty_input_s[1] ? 8'hff : mhigh_r;
                    mhigh_r <= 8'h00;
                end
                else if (ext_duty_input_s[1] && mhigh_r != 8'hff)
                    mhigh_r <= mhigh_r + 8'h01;
            end
            else
                mpre_r <= mpre_r + 16'h0001;
        end
    end
    // duty mux
    wire [15:0] prod = brightness_value_r * pin_duty_r;
    wire [15:0] prod_n = prod / 16'd255;
    reg [7:0] duty_nxt;
    always @*
    begin
        if (src_bit)
            duty_nxt = pin_duty_r;
        else if (duty_interpretation_bit)
            duty_nxt = brightness_value_r;
        else
            duty_nxt = prod_n[7:0];
    end
    // floor keeps minimum output near 2.7 percent
    wire [7:0] floored = (duty_nxt < `MIN_DUTY_FLOOR) ? `MIN_DUTY_FLOOR : duty_nxt;
    wire pwm_raw;
    dimming_pwm_gen #(
        .PRESCALE(PRESCALE)
    ) u_pwm (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .duty(floored),
        .pwm_out(pwm_raw),
        .period_start()
    );
    // turn-on sequencing and status
    reg [31:0] on_cnt_r;
    reg on_r;
    always @(posedge clk)
    begin
        if (rst)
        begin
            on_cnt_r <= 32'h00000000;
            on_r <= 1'b0;
            applied_duty <= `RST_BRIGHTNESS;
            led_enable <= 1'b0;
            dimming_pwm <= 1'b0;
            backlight_on_state <= 1'b0;
            fault_and_state_r <= `RST_FAULT_STATE;
        end
        else if (ce)
        begin
            if (!on_bit || uv_s[1] || th_s[1])
            begin
                on_r <= 1'b0;
                on_cnt_r <= 32'h00000000;
            end
            else if (!on_r)
            begin
                // startup delay stays inside the turn-on bound
                if (on_cnt_r >= TURN_ON_CYCLES - 1)
                    on_r <= 1'b1;
                else
                    on_cnt_r <= on_cnt_r + 32'h00000001;
            end
            applied_duty <= src_bit ? pin_duty_r : floored;
            dimming_pwm <= pwm_raw;
            led_enable <= on_r && on_bit && pwm_raw;
            backlight_on_state <= on_r && on_bit;
            fault_and_state_r <= {2'b00,
                (pop8(ch_s2) > 4'h1),
                (pop8(ch_s2) > 4'h0),
                on_r && on_bit,
                oc_s[1],
                th_s[1],
                th_s[1] | oc_s[1] | (ch_s2 != 8'h00)};
        end
    end
endmodule
`default_nettype wire

/* backlight_regs_props.sv */
// concurrent checks on the backlight register bank ports
`default_nettype none
module backlight_regs_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic smb_data_oe,
    input wire logic smb_data_out,
    input wire logic thermal_fault_in,
    input wire logic undervoltage_in,
    input wire logic led_enable,
    input wire logic dimming_pwm,
    input wire logic backlight_on_state,
    input wire logic [7:0] applied_duty
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_off2;
        !backlight_on_state ##1 !backlight_on_state;
    endsequence
    // pins pass a two-stage synchroniser first, so allow six cycles
    sequence s_hot;
        thermal_fault_in [*6];
    endsequence
    sequence s_low_supply;
        undervoltage_in [*6];
    endsequence
    AST_LED_GATED: assert property (s_off2 |-> !led_enable)
        else $error("led enable while backlight off");
    AST_LED_PWM: assert property (led_enable |-> dimming_pwm || $past(dimming_pwm))
        else $error("led enable outside dimming pulse");
    AST_THERMAL_OFF: assert property (s_hot |-> !backlight_on_state)
        else $error("backlight on during thermal fault");
    AST_UV_OFF: assert property (s_low_supply |-> !backlight_on_state)
        else $error("backlight on during undervoltage");
    AST_DATA_LOW: assert property (smb_data_oe |-> !smb_data_out)
        else $error("data line driven high");
    AST_OE_RELEASE: assert property ($rose(smb_data_oe) |-> ##[1:120] !smb_data_oe)
        else $error("data line held too long");
    AST_RST_STATE: assert property ($fell(rst) |-> applied_duty == 8'hff && !backlight_on_state)
        else $error("wrong state after reset");
    AST_RST_PINS: assert property ($fell(rst) |-> !led_enable && !smb_data_oe && !dimming_pwm)
        else $error("outputs active after reset");
endmodule
bind backlight_dimming_ctrl_regs backlight_regs_props backlight_regs_props_i (
    .clk(clk), .rst(rst), .smb_data_oe(smb_data_oe), .smb_data_out(smb_data_out),
    .thermal_fault_in(thermal_fault_in), .undervoltage_in(undervoltage_in),
    .led_enable(led_enable), .dimming_pwm(dimming_pwm),
    .backlight_on_state(backlight_on_state), .applied_duty(applied_duty));
`default_nettype wire

/* smbus_host_model.sv */
// smbus host model: drives the clock and pulls the data line low
`default_nettype none
module smbus_host_model (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end
    task q;
        repeat (2) @(negedge clk);
    endtask
    // data moves mid-low so it never changes while the clock is high
    task bit_io(input logic o, output logic i);
        q;
        sda_oe = !o;
        q;
        scl = 1'b1;
        q;
        q;
        i = sda;
        scl = 1'b0;
    endtask
    task start;
        q;
        sda_oe = 1'b0;
        q;
        scl = 1'b1;
        q;
        sda_oe = 1'b1;
        q;
        scl = 1'b0;
    endtask
    task stop;
        q;
        sda_oe = 1'b1;
        q;
        scl = 1'b1;
        q;
        sda_oe = 1'b0;
        q;
    endtask
    // msb first; the extra low time lets the device drop its ack
    task byte_io(input logic [7:0] tx, input logic ab, output logic [7:0] rx, output logic ack);
        for (int k = 7; k >= 0; k--)
            bit_io(tx[k], rx[k]);
        bit_io(ab, ack);
        q;
        q;
    endtask
    task xfer(input logic [6:0] a, input logic [7:0] c, input logic rd, input logic [7:0] wd,
              output logic [7:0] d, output logic ok);
        logic [7:0] x;
        logic k0;
        logic k1;
        logic k2;
        start;
        byte_io({a, 1'b0}, 1'b1, x, k0);
        byte_io(c, 1'b1, x, k1);
        if (rd)
        begin
            start;
            byte_io({a, 1'b1}, 1'b1, x, k2);
            byte_io(8'hff, 1'b1, d, x[0]);
        end
        else
            byte_io(wd, 1'b1, x, k2);
        stop;
        ok = !(k0 | k1 | k2);
    endtask
endmodule
`default_nettype wire

/* tb_top.sv */
// self-checking bench for the backlight register bank
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [6:0] dev_addr = 7'h2c;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ext = 1'b1;
    logic hot = 1'b0;
    logic ocur = 1'b0;
    logic uv = 1'b0;
    logic [7:0] chf = 8'h00;
    logic scl;
    logic host_oe;
    logic dev_oe;
    logic led_enable;
    logic dimming_pwm;
    logic on;
    logic [7:0] applied_duty;
    int n_fail = 0;
    int comparisons = 0;
    int cyc = 0;
    wire sda = !(host_oe | dev_oe);
    backlight_dimming_ctrl_regs #(.TURN_ON_CYCLES(20), .PRESCALE(2)) backlight_dimming_ctrl_regs_i (
        .clk(clk), .rst(rst), .ce(1'b1), .smb_clk_in(scl), .smb_data_in(sda),
        .smb_data_oe(dev_oe), .smb_data_out(), .ext_duty_input(ext), .thermal_fault_in(hot),
        .overcurrent_in(ocur), .channel_fault_in(chf), .undervoltage_in(uv),
        .led_enable(led_enable), .dimming_pwm(dimming_pwm), .backlight_on_state(on),
        .applied_duty(applied_duty));
    smbus_host_model smbus_host_model_i (.clk(clk), .sda(sda), .scl(scl), .sda_oe(host_oe));
    always #10 clk = !clk;
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 50000)
        begin
            n_fail++;
            test_done;
        end
    end
    task test_done;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] c, input logic [7:0] v);
        logic [7:0] d;
        logic ok;
        smbus_host_model_i.xfer(dev_addr, c, 1'b0, v, d, ok);
        chk({7'h0, ok}, 8'h01);
    endtask
    task rd_chk(input logic [7:0] c, input logic [7:0] m, input logic [7:0] e);
        logic [7:0] d;
        logic ok;
        smbus_host_model_i.xfer(dev_addr, c, 1'b1, 8'h00, d, ok);
        chk({7'h0, ok}, 8'h01);
        chk(d & m, e);
    endtask
    task wait_on(input int n, input logic exp);
        for (int k = 0; k < n && on !== exp; k++)
            @(negedge clk);
        chk({7'h0, on}, {7'h0, exp});
    endtask
    // pin duty is measured over 512-clock windows, so give it two
    task settle;
        repeat (1200) @(negedge clk);
    endtask
    task t_reset_vals;
        chk(applied_duty, 8'hff);
        chk({7'h0, on}, 8'h00);
        rd_chk(8'h00, 8'hff, 8'hff);
        rd_chk(8'h01, 8'hff, 8'h00);
        rd_chk(8'h02, 8'hff, 8'h00);
    endtask
    task t_access;
        logic [7:0] d;
        logic ok;
        smbus_host_model_i.xfer(7'h2d, 8'h01, 1'b0, 8'h05, d, ok);
        chk({7'h0, ok}, 8'h00);
        rd_chk(8'h01, 8'hff, 8'h00);
        wr(8'h01, 8'hfc);
        rd_chk(8'h01, 8'hff, 8'h04);
        wr(8'h02, 8'hff);
        rd_chk(8'h02, 8'hff, 8'h00);
    endtask
    task t_modes;
        wr(8'h01, 8'h04);
        wr(8'h00, 8'h80);
        ext = 1'b0;
        settle;
        chk(applied_duty, 8'h80);
        wr(8'h01, 8'h00);
        settle;
        chk(applied_duty, 8'h07);
        ext = 1'b1;
        settle;
        chk(applied_duty, 8'h80);
        wr(8'h01, 8'h02);
        settle;
        chk(applied_duty, 8'hff);
        wr(8'h00, 8'h10);
        rd_chk(8'h00, 8'hff, 8'hff);
        wr(8'h01, 8'h06);
        chk(applied_duty, 8'hff);
        wr(8'h01, 8'h04);
        rd_chk(8'h00, 8'hff, 8'h80);
        wr(8'h00, 8'h00);
        chk(applied_duty, 8'h07);
        rd_chk(8'h00, 8'hff, 8'h07);
        wr(8'h00, 8'h80);
    endtask
    task t_power;
        int hi;
        hi = 0;
        wr(8'h01, 8'h05);
        wait_on(40, 1'b1);
        rd_chk(8'h02, 8'hff, 8'h08);
        repeat (600)
        begin
            @(negedge clk);
            hi += led_enable;
        end
        chk({7'h0, hi > 100 && hi < 500}, 8'h01);
        wr(8'h01, 8'h04);
        chk({7'h0, on}, 8'h00);
    endtask
    task t_faults;
        wr(8'h01, 8'h05);
        wait_on(40, 1'b1);
        hot = 1'b1;
        wait_on(8, 1'b0);
        rd_chk(8'h02, 8'hf7, 8'h03);
        hot = 1'b0;
        ocur = 1'b1;
        rd_chk(8'h02, 8'hf7, 8'h05);
        ocur = 1'b0;
        chf = 8'h10;
        rd_chk(8'h02, 8'hf7, 8'h11);
        chf = 8'h81;
        rd_chk(8'h02, 8'hf7, 8'h31);
        chf = 8'h00;
        wr(8'h01, 8'h04);
        wr(8'h01, 8'h05);
        wait_on(40, 1'b1);
        uv = 1'b1;
        wait_on(8, 1'b0);
        rd_chk(8'h01, 8'hff, 8'h05);
        rd_chk(8'h02, 8'h08, 8'h00);
        uv = 1'b0;
        wait_on(100, 1'b1);
    endtask
    initial
    begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        t_reset_vals;
        t_access;
        t_modes;
        t_power;
        t_faults;
        rst = 1'b1;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        t_reset_vals;
        test_done;
    end
endmodule
`default_nettype wire
